//--- include/evirq_regs.svh
// Notes on behaviour
// - Group delay is a 4-bit code, 0 least and 15 most, reset to 8.
// - Group delay moves the I and Q outputs together, never one alone.
// - Delay spans -4 to +3.5 converter periods in half-period steps.
// - Mode bit 7 latches a calibration-ok rise, irq low; else live.
// - Mode bit 6 latches a calibration-bad event, irq low; else live.
// - Mode bit 5 latches a converter loop unlock, irq low; else live.
// - Mode bit 4 latches a converter loop lock, irq low; else live.
// - Mode bit 3 latches a link loop unlock, irq low; else live.
// - Mode bit 2 latches a link loop lock, irq low; else live.
// - Mode bit 1 latches a lane buffer error, irq low; else live.
// - Second mode bit 3 latches a channel 3 pattern error, irq low.
// - Second mode bit 2 latches a channel 2 pattern error, irq low.
// - Second mode bit 1 latches a channel 1 pattern error, irq low.
`ifndef EVIRQ_REGS_SVH
`define EVIRQ_REGS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define EVQ_ADDR_PROT 15'h0013
`define EVQ_ADDR_GDLY 15'h0014
`define EVQ_ADDR_MODE0 15'h001F
`define EVQ_ADDR_MODE1 15'h0020
`define EVQ_ADDR_STAT0 15'h0080
`define EVQ_ADDR_STAT1 15'h0081
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define EVQ_GDLY_RST 4'h8
`define EVQ_GDLY_MID 5'h08
`define EVQ_PROT_ROUTE 3
`define EVQ_PROT_SW 2
`define EVQ_M0_MASK 8'hFE
`define EVQ_M1_MASK 8'h0E
`define EVQ_NEV 10
`define EVQ_N0 7
`define EVQ_PIN_IDLE 3'h4
// ----------------------------------------
// serial frame
// ----------------------------------------
`define EVQ_INSTR_BITS 5'h10
`define EVQ_FRAME_BITS 5'h18
`define EVQ_RW_BIT 15
`endif

//--- include/evirq_pkg.sv
package evirq_pkg;
  `include "evirq_regs.svh"
  typedef enum logic [1:0] {
    SPI_IDLE,
    SPI_INSTR,
    SPI_DATA,
    SPI_HOLD
  } evirq_spi_t;
  typedef logic [`EVQ_NEV-1:0] evirq_ev_t;
endpackage : evirq_pkg

//--- include/evirq_bus_if.sv
`timescale 1ns/1ps
interface evirq_bus_if;
  logic wr;
  logic rd;
  logic [14:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport spi (output wr, rd, addr, wdata, input rdata);
  modport regs (input wr, rd, addr, wdata, output rdata);
endinterface : evirq_bus_if

//--- rtl/evirq_evt.sv
`timescale 1ns/1ps
module evirq_evt (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic mode,
  input wire logic live,
  input wire logic clr,
  // status
  output logic stat,
  output logic pend
);
  logic prev;
  logic lat;
  logic next_lat;
  // set wins over a clear in the same cycle
  always_comb begin
    next_lat = mode & ((lat & ~clr) | (live & ~prev));
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      prev <= 1'b0;
      lat <= 1'b0;
    end else begin
      prev <= live;
      lat <= next_lat;
    end
  end
  assign stat = mode ? lat : live;
  assign pend = lat;
endmodule : evirq_evt

//--- rtl/evirq_spi.sv
`timescale 1ns/1ps
`include "evirq_regs.svh"
module evirq_spi
  import evirq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // register side
  evirq_bus_if.spi bus
);
  logic [2:0] sync1, sync2, sync3, filt, filt_d;
  logic [2:0] next_filt;
  evirq_spi_t state, next_state;
  logic [4:0] cnt, next_cnt;
  logic [15:0] sh, next_sh;
  logic [7:0] tx, next_tx;
  logic rw, next_rw, next_wr, next_rd;
  logic [14:0] next_addr;
  logic [7:0] next_wdata;
  logic act, rise, fall, din;
  // ----------------------------------------
  // pin filter
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      next_filt[i] = (sync2[i] == sync3[i]) ? sync3[i] : filt[i];
    end
  end
  assign act = ~filt[2];
  assign rise = filt[1] & ~filt_d[1];
  assign fall = ~filt[1] & filt_d[1];
  assign din = filt[0];
  // ----------------------------------------
  // frame sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_sh = sh;
    next_tx = tx;
    next_rw = rw;
    next_addr = bus.addr;
    next_wdata = bus.wdata;
    next_wr = 1'b0;
    next_rd = 1'b0;
    if (bus.rd) begin
      next_tx = bus.rdata;
    end
    if (!act) begin
      next_state = SPI_IDLE;
      next_cnt = 5'h00;
    end else begin
      case (state)
        SPI_IDLE: begin
          next_state = SPI_INSTR;
        end
        SPI_INSTR: begin
          if (rise) begin
            next_sh = {sh[14:0], din};
            next_cnt = cnt + 5'h01;
            if (next_cnt == `EVQ_INSTR_BITS) begin
              next_rw = next_sh[`EVQ_RW_BIT];
              next_addr = next_sh[14:0];
              next_rd = next_sh[`EVQ_RW_BIT];
              next_state = SPI_DATA;
            end
          end
        end
        SPI_DATA: begin
          if (fall && rw && cnt != `EVQ_INSTR_BITS) begin
            next_tx = {tx[6:0], 1'b0};
          end
          if (rise) begin
            next_sh = {sh[14:0], din};
            next_cnt = cnt + 5'h01;
            if (next_cnt == `EVQ_FRAME_BITS) begin
              next_wr = ~rw;
              next_wdata = next_sh[7:0];
              next_state = SPI_HOLD;
            end
          end
        end
        default: begin
          next_state = SPI_HOLD;
        end
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1 <= `EVQ_PIN_IDLE;
      sync2 <= `EVQ_PIN_IDLE;
      sync3 <= `EVQ_PIN_IDLE;
      filt <= `EVQ_PIN_IDLE;
      filt_d <= `EVQ_PIN_IDLE;
      state <= SPI_IDLE;
      cnt <= 5'h00;
      sh <= 16'h0000;
      tx <= 8'h00;
      rw <= 1'b0;
      bus.addr <= 15'h0000;
      bus.wdata <= 8'h00;
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
    end else begin
      sync1 <= {cs_n, sclk, sdi};
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
      filt_d <= filt;
      state <= next_state;
      cnt <= next_cnt;
      sh <= next_sh;
      tx <= next_tx;
      rw <= next_rw;
      bus.addr <= next_addr;
      bus.wdata <= next_wdata;
      bus.wr <= next_wr;
      bus.rd <= next_rd;
    end
  end
  assign sdo = tx[7];
  assign sdo_oe = (state == SPI_DATA) && rw;
endmodule : evirq_spi

//--- rtl/evirq_top.sv
`timescale 1ns/1ps
`include "evirq_regs.svh"
module evirq_top
  import evirq_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // serial control port
  input wire logic SPI_CS_N,
  input wire logic SPI_SCLK,
  input wire logic SPI_SDI,
  output logic SPI_SDO,
  output logic SPI_SDO_OE,
  // device events
  input wire logic CALIBRATION_OK_EVENT,
  input wire logic CALIBRATION_BAD_EVENT,
  input wire logic CONV_LOOP_UNLOCK_EVENT,
  input wire logic CONV_LOOP_LOCKED_EVENT,
  input wire logic LINK_LOOP_UNLOCK_EVENT,
  input wire logic LINK_LOOP_LOCKED_EVENT,
  input wire logic LANE_BUFFER_ERROR_EVENT,
  input wire logic PATTERN_ERROR_CH1,
  input wire logic PATTERN_ERROR_CH2,
  input wire logic PATTERN_ERROR_CH3,
  // interrupt
  output logic IRQ_N,
  // delay and guard outputs
  output logic [3:0] JOINT_OUTPUT_DELAY,
  output logic [4:0] DELAY_I_HALF,
  output logic [4:0] DELAY_Q_HALF,
  output logic [1:0] GUARD_OUTPUT_PINS
);
  evirq_bus_if bus ();
  logic [3:0] gdly;
  logic [3:0] next_gdly;
  logic [7:0] mode0;
  logic [7:0] next_mode0;
  logic [7:0] mode1;
  logic [7:0] next_mode1;
  logic route;
  logic next_route;
  logic swp;
  logic next_swp;
  logic next_irq_n;
  logic [4:0] next_half;
  logic [1:0] next_guard;
  logic [7:0] clr0;
  logic [7:0] clr1;
  logic [7:0] rdata;
  evirq_ev_t live;
  evirq_ev_t mode_v;
  evirq_ev_t clr_v;
  evirq_ev_t stat;
  evirq_ev_t pend;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic logic hit(
    input logic [14:0] addr,
    input logic [14:0] reg_addr
  );
    hit = (addr == reg_addr);
  endfunction : hit

  // ----------------------------------------
  // serial port
  // ----------------------------------------
  evirq_spi u_spi (
    .clk(CLK_SYS),
    .rst(RST),
    .cs_n(SPI_CS_N),
    .sclk(SPI_SCLK),
    .sdi(SPI_SDI),
    .sdo(SPI_SDO),
    .sdo_oe(SPI_SDO_OE),
    .bus(bus.spi)
  );

  // ----------------------------------------
  // event sources
  // ----------------------------------------
  assign live[0] = LANE_BUFFER_ERROR_EVENT;
  assign live[1] = LINK_LOOP_LOCKED_EVENT;
  assign live[2] = LINK_LOOP_UNLOCK_EVENT;
  assign live[3] = CONV_LOOP_LOCKED_EVENT;
  assign live[4] = CONV_LOOP_UNLOCK_EVENT;
  assign live[5] = CALIBRATION_BAD_EVENT;
  assign live[6] = CALIBRATION_OK_EVENT;
  assign live[7] = PATTERN_ERROR_CH1;
  assign live[8] = PATTERN_ERROR_CH2;
  assign live[9] = PATTERN_ERROR_CH3;

  // ----------------------------------------
  // mode and clear vectors
  // ----------------------------------------
  assign mode_v = {mode1[3:1], mode0[`EVQ_N0:1]};
  assign clr0 = (bus.wr && hit(bus.addr, `EVQ_ADDR_STAT0)) ?
    bus.wdata : 8'h00;
  assign clr1 = (bus.wr && hit(bus.addr, `EVQ_ADDR_STAT1)) ?
    bus.wdata : 8'h00;
  assign clr_v = {clr1[3:1], clr0[`EVQ_N0:1]};

  // ----------------------------------------
  // event cells
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `EVQ_NEV; gi++) begin : g_evt
      evirq_evt u_evt (
        .clk(CLK_SYS),
        .rst(RST),
        .mode(mode_v[gi]),
        .live(live[gi]),
        .clr(clr_v[gi]),
        .stat(stat[gi]),
        .pend(pend[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // register writes and outputs
  // ----------------------------------------
  always_comb begin
    next_gdly = gdly;
    next_mode0 = mode0;
    next_mode1 = mode1;
    next_route = route;
    next_swp = swp;
    if (bus.wr) begin
      if (hit(bus.addr, `EVQ_ADDR_GDLY)) begin
        next_gdly = bus.wdata[3:0];
      end
      if (hit(bus.addr, `EVQ_ADDR_MODE0)) begin
        next_mode0 = bus.wdata & `EVQ_M0_MASK;
      end
      if (hit(bus.addr, `EVQ_ADDR_MODE1)) begin
        next_mode1 = bus.wdata & `EVQ_M1_MASK;
      end
      if (hit(bus.addr, `EVQ_ADDR_PROT)) begin
        next_route = bus.wdata[`EVQ_PROT_ROUTE];
        next_swp = bus.wdata[`EVQ_PROT_SW];
      end
    end
    next_irq_n = ~(|pend);
    next_half = {1'b0, gdly} - `EVQ_GDLY_MID;
    next_guard = {2{route & swp}};
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      gdly <= `EVQ_GDLY_RST;
      mode0 <= 8'h00;
      mode1 <= 8'h00;
      route <= 1'b0;
      swp <= 1'b0;
      IRQ_N <= 1'b1;
      JOINT_OUTPUT_DELAY <= `EVQ_GDLY_RST;
      DELAY_I_HALF <= 5'h00;
      DELAY_Q_HALF <= 5'h00;
      GUARD_OUTPUT_PINS <= 2'h0;
    end else begin
      gdly <= next_gdly;
      mode0 <= next_mode0;
      mode1 <= next_mode1;
      route <= next_route;
      swp <= next_swp;
      IRQ_N <= next_irq_n;
      JOINT_OUTPUT_DELAY <= gdly;
      DELAY_I_HALF <= next_half;
      DELAY_Q_HALF <= next_half;
      GUARD_OUTPUT_PINS <= next_guard;
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always_comb begin
    rdata = 8'h00;
    if (hit(bus.addr, `EVQ_ADDR_GDLY)) begin
      rdata = {4'h0, gdly};
    end
    if (hit(bus.addr, `EVQ_ADDR_MODE0)) begin
      rdata = mode0;
    end
    if (hit(bus.addr, `EVQ_ADDR_MODE1)) begin
      rdata = mode1;
    end
    if (hit(bus.addr, `EVQ_ADDR_PROT)) begin
      rdata = {4'h0, route, swp, 2'h0};
    end
    if (hit(bus.addr, `EVQ_ADDR_STAT0)) begin
      rdata = {stat[`EVQ_N0-1:0], 1'b0};
    end
    if (hit(bus.addr, `EVQ_ADDR_STAT1)) begin
      rdata = {4'h0, stat[`EVQ_NEV-1:`EVQ_N0], 1'b0};
    end
  end
  assign bus.rdata = rdata;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_ok_rise;
    mode0[7] && $rose(CALIBRATION_OK_EVENT);
  endsequence

  sequence s_ok_held;
    s_ok_rise ##1 mode0[7];
  endsequence

  property p_cal_ok;
    @(posedge CLK_SYS) disable iff (RST)
    s_ok_held |-> ##1 !IRQ_N;
  endproperty
  a_cal_ok: assert property (p_cal_ok)
    else $error("calibration ok event did not pull interrupt low");

  property p_cal_bad;
    @(posedge CLK_SYS) disable iff (RST)
    mode0[6] && $rose(CALIBRATION_BAD_EVENT) |=> stat[5];
  endproperty
  a_cal_bad: assert property (p_cal_bad)
    else $error("calibration bad event not latched");

  property p_conv_live;
    @(posedge CLK_SYS) disable iff (RST)
    !mode0[5] |-> stat[4] == CONV_LOOP_UNLOCK_EVENT;
  endproperty
  a_conv_live: assert property (p_conv_live)
    else $error("converter unlock status not live");

  property p_irq_hold;
    @(posedge CLK_SYS) disable iff (RST)
    (|pend) |=> !IRQ_N;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt released while an event is latched");

  property p_irq_free;
    @(posedge CLK_SYS) disable iff (RST)
    !(|pend) |=> IRQ_N;
  endproperty
  a_irq_free: assert property (p_irq_free)
    else $error("interrupt low with nothing latched");

  property p_gdly_rst;
    @(posedge CLK_SYS) disable iff (RST)
    $fell(RST) |-> gdly == `EVQ_GDLY_RST;
  endproperty
  a_gdly_rst: assert property (p_gdly_rst)
    else $error("group delay not at reset value");

  property p_iq_joint;
    @(posedge CLK_SYS) disable iff (RST)
    $changed(DELAY_I_HALF) |-> DELAY_I_HALF == DELAY_Q_HALF;
  endproperty
  a_iq_joint: assert property (p_iq_joint)
    else $error("I and Q delay moved apart");

  property p_span;
    @(posedge CLK_SYS) disable iff (RST)
    !$fell(RST) |-> ##1
      5'(DELAY_I_HALF + `EVQ_GDLY_MID) == {1'b0, $past(gdly)};
  endproperty
  a_span: assert property (p_span)
    else $error("half step delay does not match code");

  property p_guard_on;
    @(posedge CLK_SYS) disable iff (RST)
    route && swp |=> GUARD_OUTPUT_PINS == 2'h3;
  endproperty
  a_guard_on: assert property (p_guard_on)
    else $error("guard outputs not driven");

  property p_guard_off;
    @(posedge CLK_SYS) disable iff (RST)
    !route |=> GUARD_OUTPUT_PINS == 2'h0;
  endproperty
  a_guard_off: assert property (p_guard_off)
    else $error("guard outputs driven without routing");

endmodule : evirq_top

//--- tb/evirq_host.sv
`timescale 1ns/1ps
module evirq_host (
  // clock
  input wire logic clk,
  // serial pins
  input wire logic sdo,
  input wire logic sdo_oe,
  output logic cs_n,
  output logic sclk,
  output logic sdi
);
  // ----------------------------------------
  // idle pins
  // ----------------------------------------
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // ----------------------------------------
  // one frame: 16 instruction bits, 8 data bits, msb first
  // ----------------------------------------
  task automatic xfer(input logic rd, input logic [14:0] a,
      input logic [7:0] wd, output logic [7:0] q);
    logic [23:0] frame;
    frame = {rd, a, wd};
    q = 8'h00;
    cs_n <= 1'b0;
    repeat (8) @(negedge clk);
    for (int i = 23; i >= 0; i--) begin
      sdi <= frame[i];
      repeat (8) @(negedge clk);
      if (rd && i < 8) begin
        q[i] = sdo_oe ? sdo : 1'bx;
      end
      sclk <= 1'b1;
      repeat (8) @(negedge clk);
      sclk <= 1'b0;
    end
    repeat (8) @(negedge clk);
    cs_n <= 1'b1;
    sdi <= ~sdi;
    repeat (8) @(negedge clk);
  endtask : xfer
endmodule : evirq_host

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int LIMIT = 50000;
  logic CLK_SYS;
  logic RST;
  logic cs_n, sclk, sdi, sdo, sdo_oe;
  logic [9:0] ev;
  logic irq_n;
  logic [3:0] jdly;
  logic [4:0] dly_i, dly_q, e5;
  logic [1:0] guard;
  logic [14:0] ma, sa;
  logic [7:0] b;
  logic [3:0] codes [3] = '{4'h0, 4'hF, 4'h7};
  int err_count, checked, cycles;
  // ----------------------------------------
  // design and host
  // ----------------------------------------
  evirq_top dut (
    .CLK_SYS(CLK_SYS), .RST(RST),
    .SPI_CS_N(cs_n), .SPI_SCLK(sclk), .SPI_SDI(sdi),
    .SPI_SDO(sdo), .SPI_SDO_OE(sdo_oe),
    .CALIBRATION_OK_EVENT(ev[0]), .CALIBRATION_BAD_EVENT(ev[1]),
    .CONV_LOOP_UNLOCK_EVENT(ev[2]), .CONV_LOOP_LOCKED_EVENT(ev[3]),
    .LINK_LOOP_UNLOCK_EVENT(ev[4]), .LINK_LOOP_LOCKED_EVENT(ev[5]),
    .LANE_BUFFER_ERROR_EVENT(ev[6]), .PATTERN_ERROR_CH1(ev[7]),
    .PATTERN_ERROR_CH2(ev[8]), .PATTERN_ERROR_CH3(ev[9]),
    .IRQ_N(irq_n), .JOINT_OUTPUT_DELAY(jdly),
    .DELAY_I_HALF(dly_i), .DELAY_Q_HALF(dly_q),
    .GUARD_OUTPUT_PINS(guard)
  );
  evirq_host host (
    .clk(CLK_SYS), .sdo(sdo), .sdo_oe(sdo_oe),
    .cs_n(cs_n), .sclk(sclk), .sdi(sdi)
  );
  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.xfer(1'b0, a, d, q);
  endtask : wr
  task automatic chk_reg(input logic [14:0] a, input logic [7:0] exp);
    logic [7:0] q;
    host.xfer(1'b1, a, 8'h00, q);
    checked++;
    if (q !== exp) begin
      err_count++;
      $display("unexpected at %0t: reg %h read %h exp %h", $time, a, q, exp);
    end
  endtask : chk_reg
  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp,
      input string what);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s is %h exp %h", $time, what, got, exp);
    end
  endtask : chk_pin
  task automatic results;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results
  // ----------------------------------------
  // clock and timeout
  // ----------------------------------------
  initial begin
    CLK_SYS = 1'b0;
    forever #50 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_count++;
      results();
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    RST = 1'b1;
    ev = 10'h000;
    err_count = 0;
    checked = 0;
    cycles = 0;
    repeat (3) @(negedge CLK_SYS);
    RST <= 1'b0;
    repeat (8) @(negedge CLK_SYS);
    chk_pin({7'h00, irq_n}, 8'h01, "irq");
    chk_pin({4'h0, jdly}, 8'h08, "delay code");
    chk_pin({3'h0, dly_i}, 8'h00, "i offset");
    chk_pin({3'h0, dly_q}, 8'h00, "q offset");
    chk_pin({6'h00, guard}, 8'h00, "guard");
    chk_reg(15'h0014, 8'h08);
    chk_reg(15'h001F, 8'h00);
    chk_reg(15'h0020, 8'h00);
    chk_reg(15'h0055, 8'h00);
    // delay codes at both ends and mid range
    foreach (codes[k]) begin
      e5 = {1'b0, codes[k]} - 5'h08;
      wr(15'h0014, {4'hF, codes[k]});
      chk_reg(15'h0014, {4'h0, codes[k]});
      chk_pin({4'h0, jdly}, {4'h0, codes[k]}, "delay code");
      chk_pin({3'h0, dly_i}, {3'h0, e5}, "i offset");
      chk_pin({3'h0, dly_q}, {3'h0, e5}, "q offset");
    end
    // software protect with and without routing
    wr(15'h0013, 8'h04);
    chk_pin({6'h00, guard}, 8'h00, "guard");
    wr(15'h0013, 8'h0C);
    chk_pin({6'h00, guard}, 8'h03, "guard");
    chk_reg(15'h0013, 8'h0C);
    wr(15'h0013, 8'h08);
    chk_pin({6'h00, guard}, 8'h00, "guard");
    // every event in live mode, then latched mode
    for (int i = 0; i < 10; i++) begin
      ma = (i < 7) ? 15'h001F : 15'h0020;
      sa = (i < 7) ? 15'h0080 : 15'h0081;
      b = (i < 7) ? (8'h80 >> i) : (8'h01 << (i - 6));
      ev[i] <= 1'b1;
      repeat (3) @(negedge CLK_SYS);
      chk_reg(sa, b);
      chk_pin({7'h00, irq_n}, 8'h01, "irq");
      ev[i] <= 1'b0;
      repeat (3) @(negedge CLK_SYS);
      chk_reg(sa, 8'h00);
      wr(ma, b);
      ev[i] <= 1'b1;
      repeat (3) @(negedge CLK_SYS);
      chk_pin({7'h00, irq_n}, 8'h00, "irq");
      ev[i] <= 1'b0;
      chk_reg(sa, b);
      chk_pin({7'h00, irq_n}, 8'h00, "irq");
      wr(sa, b);
      chk_reg(sa, 8'h00);
      chk_pin({7'h00, irq_n}, 8'h01, "irq");
      wr(ma, 8'h00);
    end
    // two latched events, cleared one at a time
    wr(15'h001F, 8'hC0);
    ev[1:0] <= 2'b11;
    repeat (3) @(negedge CLK_SYS);
    ev[1:0] <= 2'b00;
    wr(15'h0080, 8'h80);
    chk_reg(15'h0080, 8'h40);
    chk_pin({7'h00, irq_n}, 8'h00, "irq");
    wr(15'h0080, 8'h40);
    chk_pin({7'h00, irq_n}, 8'h01, "irq");
    results();
  end
endmodule : testbench
